// ===== inc/eecc_pkg.sv
// Shared constants, command codes and request carrier of the EEPROM command controller
package eecc_pkg;

	// Register byte addresses
	localparam logic [7:0] OFF_COMMAND   = 8'hb0;
	localparam logic [7:0] OFF_DATA      = 8'hb4;
	localparam logic [7:0] OFF_INT_STAT  = 8'hb8;
	localparam logic [7:0] OFF_INT_MASK  = 8'hbc;

	// Command register field positions
	localparam int BUSY_BIT     = 31;
	localparam int CMD_MSB      = 30;
	localparam int CMD_LSB      = 28;
	localparam int TIMEOUT_BIT  = 9;
	localparam int LOADED_BIT   = 8;
	localparam int ADDR_MSB     = 7;
	localparam int ADDR_LSB     = 0;

	// Interrupt status bits
	localparam int INT_DONE     = 0;
	localparam int INT_TIMEOUT  = 1;
	localparam int INT_RLFAIL   = 2;
	localparam int INT_W        = 3;

	// Reset values
	localparam logic [2:0] CMD_RESET   = 3'h0;
	localparam logic [7:0] ADDR_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET  = 8'h00;

	// Operation codes of the command field
	localparam logic [2:0] OP_READ       = 3'h0;
	localparam logic [2:0] OP_WR_DISABLE = 3'h1;
	localparam logic [2:0] OP_WR_ENABLE  = 3'h2;
	localparam logic [2:0] OP_WRITE      = 3'h3;
	localparam logic [2:0] OP_WRITE_ALL  = 3'h4;
	localparam logic [2:0] OP_ERASE      = 3'h5;
	localparam logic [2:0] OP_ERASE_ALL  = 3'h6;
	localparam logic [2:0] OP_RELOAD     = 3'h7;

	// Station address image
	localparam logic [7:0] SIGNATURE     = 8'ha5;
	localparam int         STATION_BYTES = 6;

	// Timing
	localparam int CLK_MHZ          = 50;
	localparam int CLK_PERIOD_NS    = 20;
	localparam int SK_HALF_NS       = 500;
	localparam int SK_HALF_CYCLES   = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_US       = 30000;
	localparam int TIMEOUT_CYCLES   = TIMEOUT_US * CLK_MHZ;

	// Serial frame: start bit, two opcode bits, seven address bits, eight data bits
	localparam int FRAME_W = 18;

	typedef struct packed {
		logic [FRAME_W-1:0] frame;
		logic [4:0]         nout;
		logic               rd;
		logic               wait_rdy;
	} eecc_req_t;

	function automatic eecc_req_t eecc_build(input logic [2:0] op, input logic [6:0] addr,
		input logic [7:0] data);
		eecc_req_t r;
		r = '0;
		unique case (op)
			OP_READ, OP_RELOAD:
			begin
				r.frame = {3'b110, addr, 8'h00};
				r.nout  = 5'h0a;
				r.rd    = 1'b1;
			end
			OP_WR_DISABLE:
			begin
				r.frame = {3'b100, 7'h00, 8'h00};
				r.nout  = 5'h0a;
			end
			OP_WR_ENABLE:
			begin
				r.frame = {3'b100, 7'h60, 8'h00};
				r.nout  = 5'h0a;
			end
			OP_WRITE:
			begin
				r.frame    = {3'b101, addr, data};
				r.nout     = 5'h12;
				r.wait_rdy = 1'b1;
			end
			OP_WRITE_ALL:
			begin
				r.frame    = {3'b100, 7'h20, data};
				r.nout     = 5'h12;
				r.wait_rdy = 1'b1;
			end
			OP_ERASE:
			begin
				r.frame    = {3'b111, addr, 8'h00};
				r.nout     = 5'h0a;
				r.wait_rdy = 1'b1;
			end
			OP_ERASE_ALL:
			begin
				r.frame    = {3'b100, 7'h40, 8'h00};
				r.nout     = 5'h0a;
				r.wait_rdy = 1'b1;
			end
		endcase
		return r;
	endfunction

endpackage

// ===== logic/eecc_timer.sv
// Periodic cycle counter: pulses tick once every LIMIT cycles while run is high
`timescale 1ns/1ps
`default_nettype none
module eecc_timer #(
	parameter int unsigned LIMIT = 2
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      tick
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	logic [W-1:0] count_reg;

	// Dropping run restarts the count so every window is full length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else if (!run || count_reg == LAST)
			count_reg <= '0;
		else
			count_reg <= count_reg + W'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick <= 1'b0;
		else
			tick <= run && count_reg == LAST;
	end
endmodule // eecc_timer
`default_nettype wire

// ===== logic/eecc_serial.sv
// Serial EEPROM frame engine: shifts a frame out, optionally a byte in, then for write and erase requests waits for ready
`timescale 1ns/1ps
`default_nettype none
module eecc_serial (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              sk_tick,
	input  wire logic              start,
	input  wire logic              abort,
	input  wire eecc_pkg::eecc_req_t req,
	input  wire logic              ee_dout,
	output logic                   ee_cs,
	output logic                   ee_sk,
	output logic                   ee_din,
	output logic [7:0]             rdata,
	output logic                   done
);
	typedef enum logic [2:0] {S_IDLE, S_SHIFT, S_CSLOW, S_WAIT} eecc_ser_t;

	eecc_ser_t                     state_reg;
	logic [eecc_pkg::FRAME_W-1:0]  shift_reg;
	logic [4:0]                    idx_reg;
	logic [4:0]                    total_reg;
	logic [4:0]                    nout_reg;
	logic                          wait_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= S_IDLE;
			shift_reg <= '0;
			idx_reg   <= '0;
			total_reg <= '0;
			nout_reg  <= '0;
			wait_reg  <= 1'b0;
			ee_cs     <= 1'b0;
			ee_sk     <= 1'b0;
			ee_din    <= 1'b0;
			rdata     <= 8'h00;
			done      <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (abort)
			begin
				state_reg <= S_IDLE;
				ee_cs     <= 1'b0;
				ee_sk     <= 1'b0;
				ee_din    <= 1'b0;
			end
			else
			begin
				unique case (state_reg)
					S_IDLE:
					begin
						if (start)
						begin
							shift_reg <= req.frame;
							ee_din    <= req.frame[eecc_pkg::FRAME_W-1];
							nout_reg  <= req.nout;
							total_reg <= req.rd ? req.nout + 5'h08 : req.nout;
							wait_reg  <= req.wait_rdy;
							idx_reg   <= '0;
							ee_cs     <= 1'b1;
							state_reg <= S_SHIFT;
						end
					end
					S_SHIFT:
					begin
						if (sk_tick && !ee_sk)
						begin
							ee_sk <= 1'b1;
							// Device drives read data, sampled on the rising edge
							if (idx_reg >= nout_reg)
								rdata <= {rdata[6:0], ee_dout};
						end
						else if (sk_tick)
						begin
							ee_sk     <= 1'b0;
							idx_reg   <= idx_reg + 5'h01;
							shift_reg <= {shift_reg[eecc_pkg::FRAME_W-2:0], 1'b0};
							ee_din    <= shift_reg[eecc_pkg::FRAME_W-2];
							if (idx_reg + 5'h01 == total_reg)
							begin
								ee_cs     <= 1'b0;
								ee_din    <= 1'b0;
								state_reg <= wait_reg ? S_CSLOW : S_IDLE;
								done      <= !wait_reg;
							end
						end
					end
					S_CSLOW:
					begin
						// Chip select must drop once before the ready status is visible
						if (sk_tick)
						begin
							ee_cs     <= 1'b1;
							state_reg <= S_WAIT;
						end
					end
					S_WAIT:
					begin
						if (sk_tick && ee_dout)
						begin
							ee_cs     <= 1'b0;
							done      <= 1'b1;
							state_reg <= S_IDLE;
						end
					end
				endcase
			end
		end
	end
endmodule // eecc_serial
`default_nettype wire

// ===== logic/eecc_top.sv
// EEPROM command controller: APB registers, command sequencing, reload and timeout
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eecc_top #(
	parameter int unsigned TIMEOUT_CYCLES = eecc_pkg::TIMEOUT_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             ee_cs,
	output logic             ee_sk,
	output logic             ee_din,
	input  wire logic        ee_dout,
	output logic [47:0]      station_addr,
	output logic             station_valid
);
	typedef enum logic [2:0] {T_IDLE, T_START, T_RUN, T_RL_START, T_RL_RUN} eecc_top_t;

	eecc_top_t                 state_reg;
	logic [2:0]                cmd_reg;
	logic [7:0]                addr_reg;
	logic [7:0]                eeprom_data_reg;
	logic                      controller_busy_bit;
	logic                      operation_timeout_flag;
	logic                      loaded_reg;
	logic [2:0]                rl_idx_reg;
	logic [eecc_pkg::INT_W-1:0] int_stat_reg;
	logic [eecc_pkg::INT_W-1:0] int_stat_next;
	logic [eecc_pkg::INT_W-1:0] int_mask_reg;
	logic [eecc_pkg::INT_W-1:0] int_event;
	eecc_pkg::eecc_req_t       req;
	logic                      sk_tick;
	logic                      to_tick;
	logic                      eng_start;
	logic                      eng_done;
	logic [7:0]                eng_rdata;
	logic                      op_running;
	logic                      acc;
	logic                      wr_acc;
	logic                      mapped;
	logic [31:0]               rd_mux;
	logic                      host_start;

	// APB answers one cycle into the access phase so read data comes from a flip-flop
	assign acc    = psel && penable && pready;
	assign wr_acc = acc && pwrite;
	assign mapped = paddr == eecc_pkg::OFF_COMMAND || paddr == eecc_pkg::OFF_DATA ||
		paddr == eecc_pkg::OFF_INT_STAT || paddr == eecc_pkg::OFF_INT_MASK;

	assign host_start = wr_acc && paddr == eecc_pkg::OFF_COMMAND && !controller_busy_bit &&
		pwdata[eecc_pkg::BUSY_BIT];

	assign op_running = state_reg == T_RUN || state_reg == T_RL_RUN;
	assign eng_start  = state_reg == T_START || state_reg == T_RL_START;

	always_comb
	begin
		if (state_reg == T_RL_START)
			req = eecc_pkg::eecc_build(eecc_pkg::OP_READ, 7'(rl_idx_reg), 8'h00);
		else
			req = eecc_pkg::eecc_build(cmd_reg, addr_reg[6:0], eeprom_data_reg);
	end

	eecc_timer #(
		.LIMIT (eecc_pkg::SK_HALF_CYCLES)
	) u_sk_div (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (1'b1),
		.tick    (sk_tick)
	);

	// Counts only while an operation is in flight
	eecc_timer #(
		.LIMIT (TIMEOUT_CYCLES)
	) u_timeout (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (op_running),
		.tick    (to_tick)
	);

	eecc_serial u_serial (
		.pclk    (pclk),
		.presetn (presetn),
		.sk_tick (sk_tick),
		.start   (eng_start),
		.abort   (to_tick),
		.req     (req),
		.ee_dout (ee_dout),
		.ee_cs   (ee_cs),
		.ee_sk   (ee_sk),
		.ee_din  (ee_din),
		.rdata   (eng_rdata),
		.done    (eng_done)
	);

	// Sequencer; reset lands in the station address load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg  <= T_RL_START;
			rl_idx_reg <= 3'h0;
		end
		else
		begin
			unique case (state_reg)
				T_IDLE:
				begin
					if (host_start && pwdata[eecc_pkg::CMD_MSB:eecc_pkg::CMD_LSB] ==
						eecc_pkg::OP_RELOAD)
					begin
						rl_idx_reg <= 3'h0;
						state_reg  <= T_RL_START;
					end
					else if (host_start)
						state_reg <= T_START;
				end
				T_START:
					state_reg <= T_RUN;
				T_RUN:
				begin
					if (eng_done || to_tick)
						state_reg <= T_IDLE;
				end
				T_RL_START:
					state_reg <= T_RL_RUN;
				T_RL_RUN:
				begin
					if (to_tick)
						state_reg <= T_IDLE;
					else if (eng_done)
					begin
						if ((rl_idx_reg == 3'h0 && eng_rdata != eecc_pkg::SIGNATURE) ||
							rl_idx_reg == 3'(eecc_pkg::STATION_BYTES))
							state_reg <= T_IDLE;
						else
						begin
							rl_idx_reg <= rl_idx_reg + 3'h1;
							state_reg  <= T_RL_START;
						end
					end
				end
			endcase
		end
	end

	// Busy: set by reset and by a start, cleared only when the sequencer is back at rest
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			controller_busy_bit <= 1'b1;
		else if (host_start)
			controller_busy_bit <= 1'b1;
		else if ((state_reg == T_RUN || state_reg == T_RL_RUN) && to_tick)
			controller_busy_bit <= 1'b0;
		else if (state_reg == T_RUN && eng_done)
			controller_busy_bit <= 1'b0;
		else if (state_reg == T_RL_RUN && eng_done && ((rl_idx_reg == 3'h0 &&
			eng_rdata != eecc_pkg::SIGNATURE) || rl_idx_reg == 3'(eecc_pkg::STATION_BYTES)))
			controller_busy_bit <= 1'b0;
	end

	// Command and address fields are frozen while busy, so a stray write cannot corrupt a run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_reg  <= eecc_pkg::CMD_RESET;
			addr_reg <= eecc_pkg::ADDR_RESET;
		end
		else if (wr_acc && paddr == eecc_pkg::OFF_COMMAND && !controller_busy_bit)
		begin
			cmd_reg  <= pwdata[eecc_pkg::CMD_MSB:eecc_pkg::CMD_LSB];
			addr_reg <= pwdata[eecc_pkg::ADDR_MSB:eecc_pkg::ADDR_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eeprom_data_reg <= eecc_pkg::DATA_RESET;
		else if (state_reg == T_RUN && eng_done && cmd_reg == eecc_pkg::OP_READ)
			eeprom_data_reg <= eng_rdata;
		else if (wr_acc && paddr == eecc_pkg::OFF_DATA && !controller_busy_bit)
			eeprom_data_reg <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			operation_timeout_flag <= 1'b0;
		else if (op_running && to_tick)
			operation_timeout_flag <= 1'b1;
		else if (host_start)
			operation_timeout_flag <= 1'b0;
	end

	// Station address image, valid only after a load that saw the signature
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			station_addr <= 48'h0;
			loaded_reg   <= 1'b0;
		end
		else if (state_reg == T_RL_RUN && eng_done)
		begin
			if (rl_idx_reg == 3'h0)
				loaded_reg <= 1'b0;
			else
				station_addr <= {eng_rdata, station_addr[47:8]};
			if (rl_idx_reg == 3'(eecc_pkg::STATION_BYTES))
				loaded_reg <= 1'b1;
		end
		else if (state_reg == T_RL_RUN && to_tick)
			loaded_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			station_valid <= 1'b0;
		else
			station_valid <= loaded_reg;
	end

	// Interrupt events; a set in the same cycle as a clear wins
	always_comb
	begin
		int_event = '0;
		int_event[eecc_pkg::INT_DONE]    = controller_busy_bit && !host_start &&
			(state_reg == T_RUN || state_reg == T_RL_RUN) && (eng_done || to_tick);
		int_event[eecc_pkg::INT_TIMEOUT] = op_running && to_tick;
		int_event[eecc_pkg::INT_RLFAIL]  = state_reg == T_RL_RUN && ((eng_done &&
			rl_idx_reg == 3'h0 && eng_rdata != eecc_pkg::SIGNATURE) || to_tick);
		int_stat_next = int_stat_reg;
		if (wr_acc && paddr == eecc_pkg::OFF_INT_STAT)
			int_stat_next = int_stat_next & ~pwdata[eecc_pkg::INT_W-1:0];
		int_stat_next = int_stat_next | int_event;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_stat_reg <= '0;
		else
			int_stat_reg <= int_stat_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_mask_reg <= '0;
		else if (wr_acc && paddr == eecc_pkg::OFF_INT_MASK)
			int_mask_reg <= pwdata[eecc_pkg::INT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_stat_next & int_mask_reg);
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			eecc_pkg::OFF_COMMAND:
			begin
				rd_mux[eecc_pkg::BUSY_BIT]                  = controller_busy_bit;
				rd_mux[eecc_pkg::CMD_MSB:eecc_pkg::CMD_LSB] = cmd_reg;
				rd_mux[eecc_pkg::TIMEOUT_BIT]               = operation_timeout_flag;
				rd_mux[eecc_pkg::LOADED_BIT]                = loaded_reg;
				rd_mux[eecc_pkg::ADDR_MSB:eecc_pkg::ADDR_LSB] = addr_reg;
			end
			eecc_pkg::OFF_DATA:     rd_mux[7:0] = eeprom_data_reg;
			eecc_pkg::OFF_INT_STAT: rd_mux[eecc_pkg::INT_W-1:0] = int_stat_reg;
			eecc_pkg::OFF_INT_MASK: rd_mux[eecc_pkg::INT_W-1:0] = int_mask_reg;
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait state: pready rises in the second access cycle, then drops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite)
				prdata <= rd_mux;
		end
	end
endmodule // eecc_top
`default_nettype wire

// ===== tb/eecc_top_chk.sv
// Port-level assertions for the EEPROM command controller
`timescale 1ns/1ps
`default_nettype none
module eecc_top_chk (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        irq,
	input  wire logic        ee_cs,
	input  wire logic        ee_sk,
	input  wire logic        ee_din,
	input  wire logic        station_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] hi_cnt;
	logic       mapped;
	assign mapped = paddr inside {eecc_pkg::OFF_COMMAND, eecc_pkg::OFF_DATA,
		eecc_pkg::OFF_INT_STAT, eecc_pkg::OFF_INT_MASK};
	// Length of the current SK high phase
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= ee_sk ? hi_cnt + 8'h01 : 8'h00;
	property p_one_wait;
		psel && penable && !$past(penable) |-> !pready ##1 pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late");
	property p_rdy_in_access;
		pready |-> psel && penable;
	endproperty
	a_rdy_in_access: assert property (p_rdy_in_access) else $error("stray pready");
	property p_err_with_rdy;
		pslverr |-> pready;
	endproperty
	a_err_with_rdy: assert property (p_err_with_rdy) else $error("stray pslverr");
	property p_unmapped;
		pready && !mapped && !pwrite |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_mapped;
		pready && mapped |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped refused");
	property p_sk_half;
		$fell(ee_sk) |-> hi_cnt == 8'(eecc_pkg::SK_HALF_CYCLES);
	endproperty
	a_sk_half: assert property (p_sk_half) else $error("SK high phase length");
	property p_din_hold;
		ee_cs && ee_sk && $past(ee_sk) |-> $stable(ee_din);
	endproperty
	a_din_hold: assert property (p_din_hold) else $error("din moved in SK high");
	property p_sk_in_frame;
		ee_sk |-> ee_cs;
	endproperty
	a_sk_in_frame: assert property (p_sk_in_frame) else $error("SK outside frame");
	cover property (pready && pslverr);
	cover property ($rose(irq));
	cover property ($rose(station_valid));
endmodule // eecc_top_chk
`default_nettype wire

// ===== tb/eecc_ee_model.sv
// Behavioural serial EEPROM on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module eecc_ee_model #(
	parameter int BUSY_CYC = 60
) (
	input  wire logic pclk,
	input  wire logic present,
	input  wire logic ee_cs,
	input  wire logic ee_sk,
	input  wire logic ee_din,
	output logic      ee_dout
);
	logic [7:0]  mem [128];
	logic [17:0] sh;
	logic [9:0]  h;
	logic [7:0]  rd;
	logic        wen, rdm, rbit, tog;
	int          n, bc;
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h10 + 8'(i);
		mem[0] = eecc_pkg::SIGNATURE;
		{wen, rdm, rbit, tog, n, bc, h} = '0;
	end
	always @(posedge ee_cs)
	begin
		n = 0;
		rdm = 0;
	end
	always @(posedge ee_sk)
		if (ee_cs)
		begin
			sh = {sh[16:0], ee_din};
			n++;
			if (n == 10)
				h = sh[9:0];
			if (n == 10 && sh[9:7] == 3'b110)
			begin
				rdm = 1;
				rd = mem[sh[6:0]];
			end
		end
	// Read data moves on the SK fall so it is settled at the next rise
	always @(negedge ee_sk)
		if (rdm)
		begin
			rbit = rd[7];
			rd = rd << 1;
		end
	always @(negedge ee_cs)
	begin
		if (wen && h[9:7] == 3'b101 && n == 18) mem[h[6:0]] = sh[7:0];
		if (wen && h[9:7] == 3'b111) mem[h[6:0]] = 8'hff;
		if (wen && h[9:5] == 5'b10001) foreach (mem[i]) mem[i] = sh[7:0];
		if (wen && h[9:5] == 5'b10010) foreach (mem[i]) mem[i] = 8'hff;
		if (h[9:5] == 5'b10011) wen = 1;
		if (h[9:5] == 5'b10000) wen = 0;
		bc = BUSY_CYC;
	end
	always @(posedge pclk)
	begin
		tog <= ~tog;
		if (bc > 0) bc <= bc - 1;
	end
	// A pull-down holds the line low with no device; unselected it shows noise
	assign ee_dout = !present ? 1'b0 : !ee_cs ? tog : rdm ? rbit : bc == 0;
endmodule // eecc_ee_model
`default_nettype wire

// ===== tb/eecc_top_tb.sv
// Self-checking bench for the EEPROM command controller
`timescale 1ns/1ps
`default_nettype none
module eecc_top_tb;
	localparam int TO = 20000;
	localparam logic [47:0] STN = 48'h161514131211;
	logic        pclk, presetn, psel, penable, pwrite, present;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, irq, ee_cs, ee_sk, ee_din, ee_dout, sv, e;
	logic [47:0] sa;
	int          err_total, num_checks, cyc;
	eecc_top #(.TIMEOUT_CYCLES(TO)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .ee_cs(ee_cs), .ee_sk(ee_sk),
		.ee_din(ee_din), .ee_dout(ee_dout), .station_addr(sa), .station_valid(sv));
	eecc_ee_model u_ee (.pclk(pclk), .present(present), .ee_cs(ee_cs), .ee_sk(ee_sk),
		.ee_din(ee_din), .ee_dout(ee_dout));
	initial pclk = 0;
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_total++;
			results();
		end
	end
	task automatic results();
		$display("Checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Only the cycle watchdog ends a wait that never sees pready
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic idle(input int lim);
		int k;
		k = 0;
		do
		begin
			apb(0, eecc_pkg::OFF_COMMAND, 0);
			k++;
		end while (q[31] !== 1'b0 && k < lim);
		if (q[31] !== 1'b0)
			err_total++;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [7:0] a);
		apb(1, eecc_pkg::OFF_COMMAND, {1'b1, op, 20'h0, a});
		idle(TO);
	endtask
	task automatic ee_rd(input logic [7:0] a, input logic [7:0] x);
		cmd(eecc_pkg::OP_READ, a);
		apb(0, eecc_pkg::OFF_DATA, 0);
		chk("eeprom byte", {24'h0, x}, q & 32'hff);
	endtask
	task automatic loaded(input logic [47:0] x);
		chk("loaded", 32'h100, q & 32'h8000_0300);
		apb(0, eecc_pkg::OFF_DATA, 0);
		chk("station lo", x[31:0], sa[31:0]);
		chk("station hi", {16'h0, x[47:32]}, {16'h0, sa[47:32]});
		chk("station valid", 32'h1, {31'h0, sv});
	endtask
	task automatic t_boot();
		apb(0, eecc_pkg::OFF_COMMAND, 0);
		chk("cmd at reset", 32'h8000_0000, q);
		idle(TO);
		loaded(STN);
	endtask
	task automatic t_regs();
		apb(1, eecc_pkg::OFF_INT_MASK, 32'hffff_ffff);
		apb(0, eecc_pkg::OFF_INT_MASK, 0);
		chk("mask", 32'h7, q);
		apb(1, eecc_pkg::OFF_INT_MASK, 0);
		apb(1, eecc_pkg::OFF_COMMAND, {1'b0, eecc_pkg::OP_ERASE, 20'h0, 8'h2a});
		apb(0, eecc_pkg::OFF_COMMAND, 0);
		chk("cmd field", 32'h5000_002a, q & 32'hf000_00ff);
		apb(1, eecc_pkg::OFF_DATA, 32'h5a);
		apb(0, eecc_pkg::OFF_DATA, 0);
		chk("data reg", 32'h5a, q & 32'hff);
		apb(1, 8'hc0, 32'h1);
		chk("unmapped wr", 32'h1, {31'h0, e});
		apb(0, 8'hc4, 0);
		chk("unmapped rd", 32'h0, q);
		chk("unmapped rd err", 32'h1, {31'h0, e});
	endtask
	task automatic t_read();
		apb(1, eecc_pkg::OFF_INT_STAT, 32'h7);
		apb(1, eecc_pkg::OFF_COMMAND, {1'b1, eecc_pkg::OP_READ, 20'h0, 8'h03});
		apb(0, eecc_pkg::OFF_COMMAND, 0);
		chk("busy in op", 32'h1, {31'h0, q[31]});
		apb(1, eecc_pkg::OFF_DATA, 32'h99);
		apb(1, eecc_pkg::OFF_COMMAND, {1'b1, eecc_pkg::OP_ERASE, 20'h0, 8'h05});
		idle(TO);
		chk("cmd after", 32'h3, q & 32'hf000_02ff);
		apb(0, eecc_pkg::OFF_DATA, 0);
		chk("read data", 32'h13, q & 32'hff);
		apb(0, eecc_pkg::OFF_INT_STAT, 0);
		chk("done", 32'h1, q);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1, eecc_pkg::OFF_INT_MASK, 32'h1);
		apb(0, eecc_pkg::OFF_INT_STAT, 0);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1, eecc_pkg::OFF_INT_STAT, 32'h1);
		apb(0, eecc_pkg::OFF_INT_STAT, 0);
		chk("w1c", 32'h0, q | {31'h0, irq});
	endtask
	task automatic t_reload();
		cmd(eecc_pkg::OP_WR_ENABLE, 0);
		apb(1, eecc_pkg::OFF_DATA, 0);
		cmd(eecc_pkg::OP_WRITE, 0);
		apb(1, eecc_pkg::OFF_INT_STAT, 32'h7);
		cmd(eecc_pkg::OP_RELOAD, 0);
		chk("bad signature", 32'h0, q & 32'h100);
		apb(0, eecc_pkg::OFF_INT_STAT, 0);
		chk("reload fail", 32'h4, q & 32'h4);
		chk("not valid", 32'h0, {31'h0, sv});
		apb(1, eecc_pkg::OFF_DATA, {24'h0, eecc_pkg::SIGNATURE});
		cmd(eecc_pkg::OP_WRITE, 0);
		apb(1, eecc_pkg::OFF_DATA, 32'h77);
		cmd(eecc_pkg::OP_WRITE, 6);
		cmd(eecc_pkg::OP_ERASE, 1);
		cmd(eecc_pkg::OP_RELOAD, 0);
		loaded(48'h7715141312ff);
	endtask
	task automatic t_bulk();
		apb(1, eecc_pkg::OFF_DATA, 32'h3c);
		cmd(eecc_pkg::OP_WRITE_ALL, 0);
		ee_rd(8'h02, 8'h3c);
		cmd(eecc_pkg::OP_ERASE_ALL, 0);
		ee_rd(8'h02, 8'hff);
		cmd(eecc_pkg::OP_WR_DISABLE, 0);
		apb(1, eecc_pkg::OFF_DATA, 0);
		cmd(eecc_pkg::OP_WRITE, 2);
		ee_rd(8'h02, 8'hff);
	endtask
	task automatic t_timeout();
		present <= 0;
		apb(1, eecc_pkg::OFF_INT_STAT, 32'h7);
		apb(1, eecc_pkg::OFF_INT_MASK, 32'h2);
		apb(1, eecc_pkg::OFF_COMMAND, {1'b1, eecc_pkg::OP_WRITE, 20'h0, 8'h09});
		repeat (TO - 100) @(posedge pclk);
		apb(0, eecc_pkg::OFF_COMMAND, 0);
		chk("busy till timeout", 32'h1, {31'h0, q[31]});
		chk("irq early", 32'h0, {31'h0, irq});
		idle(100);
		chk("timeout flag", 32'h200, q & 32'h8000_0200);
		apb(0, eecc_pkg::OFF_INT_STAT, 0);
		chk("timeout status", 32'h3, q & 32'h3);
		chk("timeout irq", 32'h1, {31'h0, irq});
		present <= 1;
		apb(1, eecc_pkg::OFF_INT_STAT, 32'h7);
		cmd(eecc_pkg::OP_READ, 1);
		chk("flag cleared", 32'h0, q & 32'h200);
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, q, e} = '0;
		{err_total, num_checks, cyc} = '0;
		present = 1;
		presetn = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_boot();
		t_regs();
		t_read();
		t_reload();
		t_bulk();
		t_timeout();
		results();
	end
endmodule // eecc_top_tb
bind eecc_top eecc_top_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_din(ee_din), .station_valid(station_valid)
);
`default_nettype wire
